// >>> verilog/mat_pkg.sv
// Purpose : shared constants and types for the mac address hash table
// Assumes : single core clock, no software-visible registers
// Notes   : entry layout and hash settings used by both learn and lookup paths
package mat_pkg;

  // =====================================================================
  // table geometry
  localparam int TBL_ENTRIES   = 4096;
  localparam int BUCKET_COUNT  = 1024;
  localparam int BINS          = 4;
  localparam int IDX_W         = 10;
  localparam int CRC_W         = 16;
  localparam int MAC_W         = 48;
  localparam int VID_W         = 12;
  localparam int PORT_W        = 4;
  localparam int KEY_W         = MAC_W + VID_W;

  // =====================================================================
  // hash settings, shared by learn and lookup
  localparam logic [15:0] CRC_POLY = 16'h1021;   // x^16+x^12+x^5+1
  localparam logic [15:0] CRC_SEED = 16'hffff;

  // =====================================================================
  // entry: valid, static, age(recently used), port, vid, mac
  typedef struct packed {
    logic              valid;
    logic              stat;
    logic              age;
    logic [PORT_W-1:0] port;
    logic [VID_W-1:0]  vlan_identifier;
    logic [MAC_W-1:0]  mac;
  } mat_entry_t;

  localparam int ENTRY_W = $bits(mat_entry_t);

  // request from the ingress pipeline, one per received frame
  typedef struct packed {
    logic [MAC_W-1:0]  da;
    logic [MAC_W-1:0]  sa;
    logic [VID_W-1:0]  vlan_identifier;
    logic [PORT_W-1:0] src_port;
    logic              learn_ok;
  } mat_req_t;

  // lookup answer
  typedef struct packed {
    logic              hit;
    logic [PORT_W-1:0] port;
    logic              learned;
    logic              learn_full;
  } mat_rsp_t;

endpackage

// >>> verilog/mat_hash_table.sv
// Purpose : hashed mac address table, 1k buckets of four bins, lookup and learn
// Assumes : one request at most every second cycle; inputs synchronous to mclk_in
// Notes   : bins 0-1 and bins 2-3 of both da and sa buckets are read on alternate phases of a two-cycle slot
//
// Overview of operation
// - holds up to 4k address entries
// - 1k buckets of four bins each
// - four colliding addresses coexist, one per bin
// - 10-bit index, bins 0-1 then 2-3
// - all four bins used for forward and learn
// - vlan id hashed only when vlan aware
// - crc-ccitt compresses key to 16 bits
// - low ten crc bits form bucket index
// - one lookup per frame at wire speed
// - learned entry valid, age set, static clear
// - learn only into a free bin
// - forwarding index from da plus vid
// - hit needs valid and matching key
`timescale 1ns/100ps
`default_nettype none

module mat_hash_table #(
  parameter int BUCKETS = mat_pkg::BUCKET_COUNT
) (
  // clock and reset
  input  wire logic                         mclk_in,
  input  wire logic                         rstn_in,
  // configuration
  input  wire logic                         vlan_aware_enable_in,
  // request
  input  wire logic                         req_valid_in,
  input  wire mat_pkg::mat_req_t            req_in,
  output logic                              req_ready_out,
  // answer
  output logic                              rsp_valid_out,
  output mat_pkg::mat_rsp_t                 rsp_out
);

  localparam int HALF_W = 2 * mat_pkg::ENTRY_W;

  // =====================================================================
  // hash function, msb first, seed fixed
  // no final inversion; learn and lookup share this one function so they agree
  function automatic logic [15:0] crc_key(input logic [mat_pkg::KEY_W-1:0] key);
    logic [15:0] c;
    c = mat_pkg::CRC_SEED;
    for (int i = mat_pkg::KEY_W - 1; i >= 0; i--) begin
      c = {c[14:0], 1'b0} ^ ((c[15] ^ key[i]) ? mat_pkg::CRC_POLY : 16'h0000);
    end
    return c;
  endfunction

  // =====================================================================
  // key formation: vid forced to zero when not vlan aware
  // the same key feeds both the hash and the bin compare
  wire logic [mat_pkg::VID_W-1:0] key_vid = vlan_aware_enable_in ? req_in.vlan_identifier : 12'h000;
  wire logic [mat_pkg::KEY_W-1:0] da_key  = {req_in.da, key_vid};
  wire logic [mat_pkg::KEY_W-1:0] sa_key  = {req_in.sa, key_vid};
  wire logic [15:0] da_crc = crc_key(da_key);
  wire logic [15:0] sa_crc = crc_key(sa_key);
  wire logic [mat_pkg::IDX_W-1:0] da_idx = da_crc[9:0];
  wire logic [mat_pkg::IDX_W-1:0] sa_idx = sa_crc[9:0];

  // =====================================================================
  // storage: two banks per bucket, bins 0-1 and bins 2-3
  // two banks give each read cycle its own half of the bucket
  logic [HALF_W-1:0] bank_lo [BUCKETS];
  logic [HALF_W-1:0] bank_hi [BUCKETS];

  // =====================================================================
  // sequencer: one-hot, two cycles per lookup
  typedef enum logic [2:0] {
    MAT_IDLE = 3'b001,
    MAT_RD0  = 3'b010,
    MAT_RD1  = 3'b100
  } mat_state_t;

  mat_state_t                    state_reg;
  mat_state_t                    state_next;
  logic [mat_pkg::IDX_W-1:0]     da_idx_reg;
  logic [mat_pkg::IDX_W-1:0]     sa_idx_reg;
  logic [mat_pkg::KEY_W-1:0]     da_key_reg;
  logic [mat_pkg::KEY_W-1:0]     sa_key_reg;
  logic [mat_pkg::PORT_W-1:0]    src_port_reg;
  logic                          learn_ok_reg;
  logic [HALF_W-1:0]             da_lo_reg;
  logic [HALF_W-1:0]             sa_lo_reg;
  logic                          ready_reg;
  logic                          rsp_valid_reg;
  mat_pkg::mat_rsp_t             rsp_reg;

  // a request is taken where valid meets ready
  wire logic take = req_valid_in && ready_reg;

  // state transitions; a new request may be taken as the last read ends
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      MAT_IDLE: begin
        if (take) state_next = MAT_RD0;
      end
      MAT_RD0: state_next = MAT_RD1;
      MAT_RD1: begin
        // a request taken here starts its first read at once, one gap cycle apart
        state_next = take ? MAT_RD0 : MAT_IDLE;
      end
    endcase
  end

  // =====================================================================
  // second-cycle bucket contents, four bins each
  wire logic [HALF_W-1:0] da_hi = bank_hi[da_idx_reg];
  wire logic [HALF_W-1:0] sa_hi = bank_hi[sa_idx_reg];
  wire logic [4*mat_pkg::ENTRY_W-1:0] da_bkt = {da_hi, da_lo_reg};
  wire logic [4*mat_pkg::ENTRY_W-1:0] sa_bkt = {sa_hi, sa_lo_reg};

  // per-bin results of the second read cycle
  logic [mat_pkg::BINS-1:0]   da_hit;
  logic [mat_pkg::BINS-1:0]   sa_hit;
  logic [mat_pkg::BINS-1:0]   sa_free;
  mat_pkg::mat_entry_t        da_bin [mat_pkg::BINS];

  // per-bin compare and free detect
  for (genvar b = 0; b < mat_pkg::BINS; b++) begin : g_bin
    mat_pkg::mat_entry_t sb;
    assign da_bin[b]  = da_bkt[b*mat_pkg::ENTRY_W +: mat_pkg::ENTRY_W];
    assign sb         = sa_bkt[b*mat_pkg::ENTRY_W +: mat_pkg::ENTRY_W];
    assign da_hit[b]  = da_bin[b].valid && ({da_bin[b].mac, da_bin[b].vlan_identifier} == da_key_reg);
    assign sa_hit[b]  = sb.valid && ({sb.mac, sb.vlan_identifier} == sa_key_reg);
    assign sa_free[b] = !sb.valid;
  end

  // lowest hitting bin and lowest free bin
  // the loop runs from bin 3 down to bin 0, so the lowest index wins
  logic [1:0] hit_bin;
  logic [1:0] free_bin;
  always_comb begin
    hit_bin  = 2'd0;
    free_bin = 2'd0;
    for (int i = mat_pkg::BINS - 1; i >= 0; i--) begin
      if (da_hit[i]) hit_bin = 2'(i);
      if (sa_free[i]) free_bin = 2'(i);
    end
  end

  // learn decision: known sa refreshed nowhere here, unknown sa into free bin
  wire logic do_learn = (state_reg == MAT_RD1) && learn_ok_reg && !(|sa_hit) && (|sa_free);
  wire logic learn_full = (state_reg == MAT_RD1) && learn_ok_reg && !(|sa_hit) && !(|sa_free);

  // entry made by learning: valid, fresh and dynamic
  mat_pkg::mat_entry_t new_ent;
  assign new_ent.valid = 1'b1;
  assign new_ent.stat  = 1'b0;
  assign new_ent.age   = 1'b1;
  assign new_ent.port  = src_port_reg;
  assign new_ent.vlan_identifier   = sa_key_reg[mat_pkg::VID_W-1:0];
  assign new_ent.mac   = sa_key_reg[mat_pkg::KEY_W-1:mat_pkg::VID_W];

  // =====================================================================
  // control and capture registers
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_reg     <= MAT_IDLE;
      ready_reg     <= 1'b1;
      rsp_valid_reg <= 1'b0;
      rsp_reg       <= '0;
      learn_ok_reg  <= 1'b0;
    end else begin
      state_reg     <= state_next;
      // ready is low only while bins 0-1 are read, so one gap cycle separates takes
      ready_reg     <= (state_next == MAT_IDLE) || (state_reg == MAT_RD0);
      rsp_valid_reg <= (state_reg == MAT_RD1);
      if (take) learn_ok_reg <= req_in.learn_ok;
      if (state_reg == MAT_RD1) begin
        rsp_reg.hit        <= |da_hit;
        rsp_reg.port       <= da_bin[hit_bin].port;
        rsp_reg.learned    <= do_learn;
        rsp_reg.learn_full <= learn_full;
      end
    end
  end

  // request capture and first-cycle read of bins 0 and 1
  // no reset needed here: nothing is used before a take loads it
  always_ff @(posedge mclk_in) begin
    if (take) begin
      da_idx_reg   <= da_idx;
      sa_idx_reg   <= sa_idx;
      da_key_reg   <= da_key;
      sa_key_reg   <= sa_key;
      src_port_reg <= req_in.src_port;
    end
    if (state_reg == MAT_RD0) begin
      da_lo_reg <= bank_lo[da_idx_reg];
      sa_lo_reg <= bank_lo[sa_idx_reg];
    end
  end

  // table write: memory has no reset, so contents start unknown until cleared
  // kept as a plain clocked process so that a test bench may preload the table;
  // the write lands at the end of the second read, so a request taken in that
  // same cycle already sees the new entry in its own reads of either bank
  always @(posedge mclk_in) begin
    if (do_learn) begin
      if (free_bin[1]) begin
        if (free_bin[0]) bank_hi[sa_idx_reg] <= {new_ent, sa_hi[mat_pkg::ENTRY_W-1:0]};
        else bank_hi[sa_idx_reg] <= {sa_hi[HALF_W-1:mat_pkg::ENTRY_W], new_ent};
      end else begin
        if (free_bin[0]) bank_lo[sa_idx_reg] <= {new_ent, sa_lo_reg[mat_pkg::ENTRY_W-1:0]};
        else bank_lo[sa_idx_reg] <= {sa_lo_reg[HALF_W-1:mat_pkg::ENTRY_W], new_ent};
      end
    end
  end

  // every output is a register, no logic after the flops
  assign req_ready_out = ready_reg;
  assign rsp_valid_out = rsp_valid_reg;
  assign rsp_out       = rsp_reg;

endmodule

`default_nettype wire

// >>> tb/mat_hash_table_chk.sv
// Purpose: port checker for the hash table
// Assumes: one clock, reset active low
// Notes  : answer comes three edges after the take
`timescale 1ns/100ps
`default_nettype none
// ==========
// port relations
module mat_hash_table_chk #(parameter int BUCKETS = 1024) (
  // clock and reset
  input wire logic              mclk_in, rstn_in,
  // request and answer
  input wire logic              req_valid_in, req_ready_out, rsp_valid_out,
  input wire mat_pkg::mat_req_t req_in,
  input wire mat_pkg::mat_rsp_t rsp_out
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rstn_in);
  // take and learn outcome, named so the properties stay short
  wire logic take = req_valid_in && req_ready_out;
  wire logic lrn = rsp_out.learned || rsp_out.learn_full;
  ready_drop_a: assert property (take |=> !req_ready_out) else $error("ready not dropped");
  ready_back_a: assert property (!req_ready_out |=> req_ready_out) else $error("ready low too long");
  rsp_time_a: assert property (take |-> ##3 rsp_valid_out) else $error("answer late");
  rsp_cause_a: assert property (rsp_valid_out |-> $past(take, 3)) else $error("answer unasked");
  rsp_pulse_a: assert property (rsp_valid_out |=> !rsp_valid_out) else $error("answer too long");
  rsp_hold_a: assert property (!rsp_valid_out |-> $stable(rsp_out)) else $error("answer moved");
  learn_excl_a: assert property (rsp_valid_out |-> !(lrn && rsp_out.learned == rsp_out.learn_full)) else $error("both");
  learn_gate_a: assert property (rsp_valid_out && lrn |-> $past(req_in.learn_ok, 3)) else $error("bad learn");
endmodule
`default_nettype wire

// >>> tb/mat_ingress_model.sv
// Purpose: ingress pipeline stand-in, one request at a time
// Assumes: bench raises go_in with pkt_in set
// Notes  : request released on the falling edge after its take
`timescale 1ns/100ps
`default_nettype none
// ==========
// request launcher
module mat_ingress_model (
  // clock and reset
  input wire logic         mclk_in, rstn_in,
  // bench side
  input wire logic         go_in,
  input wire mat_pkg::mat_req_t pkt_in,
  // table side
  input wire logic         req_ready_in,
  output logic             req_valid_out,
  output mat_pkg::mat_req_t req_out
);
  logic taken_reg = 1'b0;
  // the take is seen on the rising edge that samples ready
  always @(posedge mclk_in) taken_reg <= req_valid_out && req_ready_in;
  // a released bus shows the inverse so stale data never passes as fresh
  always @(negedge mclk_in) begin
    if (!rstn_in || taken_reg) begin
      req_valid_out <= 1'b0;
      req_out <= ~req_out;
    end else if (go_in && !req_valid_out) begin
      req_valid_out <= 1'b1;
      req_out <= pkt_in;
    end
  end
endmodule
`default_nettype wire

// >>> tb/mat_hash_table_tb.sv
// Purpose: self-checking bench for the hash table
// Assumes: table memory cleared at time zero
// Notes  : a reference table predicts every answer
`timescale 1ns/100ps
`default_nettype none
// ==========
// bench top
module mat_hash_table_tb;
  logic mclk_in = 1'b0, rstn_in = 1'b0, vae = 1'b0, go = 1'b0, rv, rdy, rsp_valid;
  logic [47:0] m, cm[5], pool[$];
  mat_pkg::mat_req_t pkt = '0, req;
  mat_pkg::mat_rsp_t rsp, exp_v, exp_q[$];
  mat_pkg::mat_entry_t tbl[1024][4] = '{default: '0};
  int errors = 0, comparisons = 0, seed = 64;
  mat_ingress_model u_ing (.mclk_in(mclk_in), .rstn_in(rstn_in), .go_in(go), .pkt_in(pkt),
    .req_ready_in(rdy), .req_valid_out(rv), .req_out(req));
  mat_hash_table #(.BUCKETS(1024)) u_dut (.mclk_in(mclk_in), .rstn_in(rstn_in), .vlan_aware_enable_in(vae),
    .req_valid_in(rv), .req_in(req), .req_ready_out(rdy), .rsp_valid_out(rsp_valid), .rsp_out(rsp));
  initial forever #2 mclk_in = ~mclk_in;
  function automatic logic [47:0] rnd48();
    return {16'($random(seed)), 32'($random(seed))};
  endfunction
  // msb-first crc over mac then vid; low ten bits pick the bucket
  function automatic logic [9:0] idx(logic [47:0] a, logic [11:0] v);
    logic [15:0] c = mat_pkg::CRC_SEED;
    logic [59:0] d = {a, v};
    for (int i = 59; i >= 0; i--) c = {c[14:0], 1'b0} ^ (c[15] ^ d[i] ? 16'h1021 : 16'h0000);
    return c[9:0];
  endfunction
  function automatic logic same(logic [9:0] b, int i, logic [47:0] a, logic [11:0] v);
    return tbl[b][i].valid && tbl[b][i].mac == a && tbl[b][i].vlan_identifier == v;
  endfunction
  task automatic check(logic [6:0] seen, logic [6:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    if (errors == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // predict the answer, then hand the request to the ingress model
  task automatic send(logic [47:0] da, logic [47:0] sa, logic [11:0] vlan_identifier, logic lok);
    mat_pkg::mat_rsp_t e = '0;
    logic [11:0] v = vae ? vlan_identifier : 12'h000;
    logic [3:0] src = 4'(rnd48());
    logic [9:0] b = idx(da, v);
    logic pr = 1'b0;
    int fr = -1;
    for (int i = 3; i >= 0; i--) if (same(b, i, da, v)) e = {1'b1, tbl[b][i].port, 2'b00};
    b = idx(sa, v);
    for (int i = 3; i >= 0; i--) begin
      if (!tbl[b][i].valid) fr = i;
      pr |= same(b, i, sa, v);
    end
    if (lok && !pr && fr < 0) e.learn_full = 1'b1;
    if (lok && !pr && fr >= 0) {e.learned, tbl[b][fr]} = {1'b1, 3'b101, src, v, sa};
    pool.push_back(sa);
    exp_q.push_back(e);
    pkt <= {da, sa, vlan_identifier, src, lok};
    go <= 1'b1;
    @(negedge mclk_in);
    go <= 1'b0;
    // return right after the take so the next request can follow with one gap cycle
    @(posedge mclk_in);
    for (int k = 0; k < 8 && !(rv && rdy); k++) @(posedge mclk_in);
    @(negedge mclk_in);
  endtask
  // answers are compared against the oldest prediction
  always @(posedge mclk_in) begin
    if (rstn_in && rsp_valid) begin
      exp_v = '1; // an answer nobody asked for can never match
      if (exp_q.size() > 0) exp_v = exp_q.pop_front();
      check({rsp.hit, rsp.hit ? rsp.port : 4'h0, rsp.learned, rsp.learn_full}, exp_v);
    end
  end
  initial begin
    u_dut.bank_lo = '{default: '0};
    u_dut.bank_hi = '{default: '0};
    repeat (20) @(negedge mclk_in);
    rstn_in <= 1'b1;
    // five colliding addresses per mode: four fit, the fifth is refused
    for (int v = 0; v < 2; v++) begin
      vae <= v[0];
      @(negedge mclk_in);
      for (int n = 0; n < 5;) begin
        cm[n] = rnd48();
        if (idx(cm[n], v[0] ? 12'h5a5 : 12'h000) == (10'h2c3 ^ 10'(v))) n++;
      end
      for (int k = 0; k < 5; k++) send(rnd48(), cm[k], 12'h5a5, 1'b1);
      for (int k = 0; k < 10; k++) send(cm[k % 5], rnd48(), k < 5 ? 12'h5a5 : 12'h123, 1'b0);
    end
    // random back-to-back traffic mixing hits, misses and learns
    for (int k = 0; k < 300; k++) begin
      m = rnd48();
      send(m[0] ? pool[m[47:40] % pool.size()] : m, rnd48(), {10'h000, m[2:1]}, m[3]);
    end
    repeat (8) @(negedge mclk_in);
    // every request must have been answered, else a stall would pass unseen
    check(7'(exp_q.size()), 7'h00);
    give_verdict();
  end
  initial begin
    #40000;
    errors++;
    give_verdict();
  end
endmodule
bind mat_hash_table mat_hash_table_chk #(.BUCKETS(BUCKETS)) u_chk (.mclk_in(mclk_in), .rstn_in(rstn_in),
  .req_valid_in(req_valid_in), .req_ready_out(req_ready_out), .rsp_valid_out(rsp_valid_out),
  .req_in(req_in), .rsp_out(rsp_out));
`default_nettype wire
